/* File: tpc_timer_pwm.sv */
// Two-channel PWM timer with classic Wishbone register access
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module tpc_timer_pwm #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic breakActive,
  input wire logic [1:0] captureIn,
  output logic [1:0] channelOut,
  output logic [1:0] channelOe,
  output logic irqRequest
);
  if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must lie between 8 and 16");
  end

  logic busReq;
  logic wr;
  logic rd;
  logic counterResetWr;
  logic running;
  logic tick;
  logic overflowEvent;
  logic statusLock;
  logic linked;
  logic pendingSel_next;
  logic [31:0] rdData;
  logic [tpc_pkg::PRESC_W-1:0] prescLimit;
  logic [CNT_W-1:0] compareValue [2];
  logic [1:0] chEvent;
  logic [1:0] chCapture;
  logic [2:0] flagSet;
  logic [2:0] flagRd;
  logic [2:0] flagClr;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] modulo_reg;
  logic [tpc_pkg::PRESC_W-1:0] presc_reg;
  logic [tpc_pkg::PS_W-1:0] prescale_reg;
  logic halt_reg;
  logic overflowIe_reg;
  logic breakClearEnable_reg;
  logic activeSel_reg;
  logic pendingSel_reg;
  logic [tpc_pkg::CTL_W-1:0] chCtl_reg [2];
  logic [CNT_W-1:0] chVal_reg [2];
  logic [2:0] flag_reg;
  logic [2:0] arm_reg;

  function automatic logic [CNT_W-1:0] mergeWord(input logic [CNT_W-1:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0] sel);
    logic [CNT_W-1:0] res;
    res = old;
    for (int b = 0; b < CNT_W; b++) begin
      if (sel[b / 8]) begin
        res[b] = data[b];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] flagOffset(input int idx);
    logic [7:0] ofs;
    ofs = tpc_pkg::OFS_TIMER_CONTROL;
    if (idx == 1) begin
      ofs = tpc_pkg::OFS_FIRST_CHANNEL_CONTROL;
    end else if (idx == 2) begin
      ofs = tpc_pkg::OFS_SECOND_CHANNEL_CONTROL;
    end
    return ofs;
  endfunction

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  assign busReq = cyc_i && stb_i && !ack_o && !err_o;
  assign wr = busReq && we_i && !waitMode;
  assign rd = busReq && !we_i && !waitMode;
  assign counterResetWr = wr && adr_i == tpc_pkg::OFS_TIMER_CONTROL && sel_i[0]
    && dat_i[tpc_pkg::TC_COUNTER_RESET];
  assign linked = chCtl_reg[0][tpc_pkg::CC_MODE_B];

  always_comb begin
    rdData = 32'h0000_0000;
    unique case (adr_i)
      tpc_pkg::OFS_TIMER_CONTROL:
        rdData = 32'({flag_reg[0], overflowIe_reg, halt_reg, 2'b00, prescale_reg});
      tpc_pkg::OFS_COUNTER: rdData = 32'(cnt_reg);
      tpc_pkg::OFS_MODULO_VALUE: rdData = 32'(modulo_reg);
      tpc_pkg::OFS_FIRST_CHANNEL_CONTROL: rdData = 32'({flag_reg[1], chCtl_reg[0]});
      tpc_pkg::OFS_FIRST_CHANNEL_VALUE: rdData = 32'(chVal_reg[0]);
      tpc_pkg::OFS_SECOND_CHANNEL_CONTROL:
        rdData = linked ? 32'h0000_0000 : 32'({flag_reg[2], chCtl_reg[1]});
      tpc_pkg::OFS_SECOND_CHANNEL_VALUE: rdData = 32'(chVal_reg[1]);
      tpc_pkg::OFS_SYSTEM_CONTROL: rdData = 32'(breakClearEnable_reg);
      default: rdData = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses are acknowledged and read as zero; wait mode answers err
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= busReq && !waitMode;
      err_o <= busReq && waitMode;
      dat_o <= rd ? rdData : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      halt_reg <= tpc_pkg::HALT_RESET;
      overflowIe_reg <= 1'b0;
      prescale_reg <= '0;
      breakClearEnable_reg <= 1'b0;
      modulo_reg <= tpc_pkg::MODULO_RESET[CNT_W-1:0];
      chCtl_reg[0] <= tpc_pkg::CHANNEL_CONTROL_RESET;
      chCtl_reg[1] <= tpc_pkg::CHANNEL_CONTROL_RESET;
    end else if (wr) begin
      unique case (adr_i)
        tpc_pkg::OFS_TIMER_CONTROL: begin
          if (sel_i[0]) begin
            overflowIe_reg <= dat_i[tpc_pkg::TC_IRQ_ENABLE];
            halt_reg <= dat_i[tpc_pkg::TC_COUNTER_HALT];
            prescale_reg <= dat_i[tpc_pkg::TC_PRESCALE_LSB +: tpc_pkg::PS_W];
          end
        end
        tpc_pkg::OFS_MODULO_VALUE: modulo_reg <= mergeWord(modulo_reg, dat_i, sel_i);
        tpc_pkg::OFS_FIRST_CHANNEL_CONTROL: begin
          if (sel_i[0]) begin
            chCtl_reg[0] <= dat_i[tpc_pkg::CTL_W-1:0];
          end
        end
        tpc_pkg::OFS_SECOND_CHANNEL_CONTROL: begin
          if (sel_i[0] && !linked) begin
            chCtl_reg[1] <= dat_i[tpc_pkg::CTL_W-1:0];
          end
        end
        tpc_pkg::OFS_SYSTEM_CONTROL: begin
          if (sel_i[0]) begin
            breakClearEnable_reg <= dat_i[tpc_pkg::SYS_BREAK_CLEAR_ENABLE];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  assign running = !halt_reg && !stopMode && !breakActive;
  assign prescLimit = tpc_pkg::PRESC_W'((7'h01 << prescale_reg) - 7'h01);
  assign tick = running && prescale_reg != tpc_pkg::PS_NONE && presc_reg == prescLimit;
  assign overflowEvent = tick && cnt_reg == modulo_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      presc_reg <= '0;
      cnt_reg <= '0;
    end else if (counterResetWr) begin
      presc_reg <= '0;
      cnt_reg <= '0;
    end else if (running) begin
      presc_reg <= (presc_reg == prescLimit) ? '0 : presc_reg + 1'b1;
      if (tick) begin
        cnt_reg <= overflowEvent ? '0 : cnt_reg + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Channel values and buffered selection
  // ---------------------------------------------------------------
  // Capture loads win over a write landing in the same cycle
  for (genvar c = 0; c < 2; c++) begin : g_value
    localparam logic [7:0] VAL_OFS = (c == 0) ? tpc_pkg::OFS_FIRST_CHANNEL_VALUE
                                              : tpc_pkg::OFS_SECOND_CHANNEL_VALUE;
    always_ff @(posedge clk) begin
      if (rst) begin
        chVal_reg[c] <= '0;
      end else if (chCapture[c]) begin
        chVal_reg[c] <= cnt_reg;
      end else if (wr && adr_i == VAL_OFS) begin
        chVal_reg[c] <= mergeWord(chVal_reg[c], dat_i, sel_i);
      end
    end
  end

  always_comb begin
    pendingSel_next = pendingSel_reg;
    if (wr && adr_i == tpc_pkg::OFS_SECOND_CHANNEL_VALUE) begin
      pendingSel_next = 1'b1;
    end else if (wr && adr_i == tpc_pkg::OFS_FIRST_CHANNEL_VALUE) begin
      pendingSel_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !linked) begin
      activeSel_reg <= 1'b0;
      pendingSel_reg <= 1'b0;
    end else begin
      pendingSel_reg <= pendingSel_next;
      if (overflowEvent) begin
        activeSel_reg <= pendingSel_next;
      end
    end
  end

  // Writing the active register is not shadowed, so it behaves unbuffered
  assign compareValue[0] = (linked && activeSel_reg) ? chVal_reg[1] : chVal_reg[0];
  assign compareValue[1] = chVal_reg[1];

  for (genvar c = 0; c < 2; c++) begin : g_channel
    tpc_channel u_channel (
      .clk(clk),
      .rst(rst),
      .enable(c == 0 || !linked),
      .modeB(chCtl_reg[c][tpc_pkg::CC_MODE_B]),
      .modeA(chCtl_reg[c][tpc_pkg::CC_MODE_A]),
      .edgeLevelSelect(chCtl_reg[c][tpc_pkg::CC_ELS_LSB +: 2]),
      .toggleOnOverflow(chCtl_reg[c][tpc_pkg::CC_TOGGLE_ON_OVERFLOW]),
      .maxDutySelect(chCtl_reg[c][tpc_pkg::CC_MAX_DUTY]),
      .active(!stopMode),
      .overflowEvent(overflowEvent),
      .compareMatch(tick && cnt_reg == compareValue[c]),
      .captureIn(captureIn[c]),
      .channelEvent(chEvent[c]),
      .captureEvent(chCapture[c]),
      .pinOut(channelOut[c]),
      .pinOe(channelOe[c])
    );
  end

  // ---------------------------------------------------------------
  // Status flags and interrupt
  // ---------------------------------------------------------------
  // Index 0 is the overflow flag, 1 and 2 the channel event flags
  assign statusLock = breakActive && !breakClearEnable_reg;
  assign flagSet = {chEvent[1], chEvent[0], overflowEvent};

  for (genvar f = 0; f < 3; f++) begin : g_flag
    assign flagRd[f] = rd && adr_i == flagOffset(f);
    assign flagClr[f] = wr && adr_i == flagOffset(f) && sel_i[0] && !dat_i[tpc_pkg::FLAG_BIT];
    // A new event voids a pending clear, so set always beats clear
    always_ff @(posedge clk) begin
      if (rst) begin
        flag_reg[f] <= 1'b0;
        arm_reg[f] <= 1'b0;
      end else if (flagSet[f]) begin
        flag_reg[f] <= 1'b1;
        arm_reg[f] <= 1'b0;
      end else if (flagClr[f] && arm_reg[f] && !statusLock) begin
        flag_reg[f] <= 1'b0;
        arm_reg[f] <= 1'b0;
      end else if (flagRd[f] && flag_reg[f] && !statusLock) begin
        arm_reg[f] <= 1'b1;
      end
    end
  end

  // Level request; also serves as the wake request out of wait mode
  always_ff @(posedge clk) begin
    if (rst) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= (flag_reg[0] && overflowIe_reg) ||
        (flag_reg[1] && chCtl_reg[0][tpc_pkg::CC_IRQ_ENABLE]) ||
        (flag_reg[2] && chCtl_reg[1][tpc_pkg::CC_IRQ_ENABLE]);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_overflow_flag;
    overflowEvent |=> flag_reg[0] ##1 (irqRequest || !$past(overflowIe_reg));
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow not flagged");

  property p_channel_flag;
    (chEvent[0] && chCtl_reg[0][tpc_pkg::CC_IRQ_ENABLE]) |=> flag_reg[1] ##1 irqRequest;
  endproperty
  a_channel_flag: assert property (p_channel_flag) else $error("channel event lost");

  property p_wait_refused;
    (waitMode && busReq) |=> err_o && !ack_o;
  endproperty
  a_wait_refused: assert property (p_wait_refused) else $error("access taken in wait");

  property p_stop_frozen;
    (stopMode && !counterResetWr) |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_stop_frozen: assert property (p_stop_frozen) else $error("counter ran in stop");

  property p_break_halts;
    (breakActive && !counterResetWr) |=> $stable(cnt_reg);
  endproperty
  a_break_halts: assert property (p_break_halts) else $error("counter ran in break");

  property p_break_clear;
    (breakActive && breakClearEnable_reg && arm_reg[0] && flagClr[0] && !flagSet[0])
      |=> !flag_reg[0];
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("clear in break ignored");

  property p_break_protect;
    (statusLock && flag_reg[0]) |=> flag_reg[0];
  endproperty
  a_break_protect: assert property (p_break_protect) else $error("flag cleared in break");

  property p_clear_needs_read;
    (flag_reg[0] && !arm_reg[0]) |=> flag_reg[0];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("unarmed clear");

  property p_buffer_swap;
    (linked && overflowEvent) |=> activeSel_reg == $past(pendingSel_next);
  endproperty
  a_buffer_swap: assert property (p_buffer_swap) else $error("wrong buffered source");

  property p_link_start;
    !linked |=> !activeSel_reg;
  endproperty
  a_link_start: assert property (p_link_start) else $error("link not on channel 0");

  property p_pin_released;
    linked |=> !channelOe[1];
  endproperty
  a_pin_released: assert property (p_pin_released) else $error("second pin driven");

  c_overflow: cover property (overflowEvent && flag_reg[0] && arm_reg[0]);
  c_swap: cover property (linked && $rose(activeSel_reg));
  c_capture: cover property (chCapture[0]);
endmodule

/* File: tpc_pkg.sv */
// Shared register map, field positions and reset values of the PWM timer
package tpc_pkg;
  localparam int ADR_W = 8;
  localparam int PS_W = 3;
  localparam int PRESC_W = 6;
  localparam int CTL_W = 7;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNTER = 8'h04;
  localparam logic [7:0] OFS_MODULO_VALUE = 8'h08;
  localparam logic [7:0] OFS_FIRST_CHANNEL_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_FIRST_CHANNEL_VALUE = 8'h10;
  localparam logic [7:0] OFS_SECOND_CHANNEL_CONTROL = 8'h14;
  localparam logic [7:0] OFS_SECOND_CHANNEL_VALUE = 8'h18;
  localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h1c;
  // ---------------------------------------------------------------
  // Timer control fields
  // ---------------------------------------------------------------
  localparam int FLAG_BIT = 7;
  localparam int TC_IRQ_ENABLE = 6;
  localparam int TC_COUNTER_HALT = 5;
  localparam int TC_COUNTER_RESET = 4;
  localparam int TC_PRESCALE_LSB = 0;
  localparam logic [2:0] PS_NONE = 3'h7;
  localparam logic HALT_RESET = 1'b1;
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  // ---------------------------------------------------------------
  // Channel control fields (below the event flag)
  // ---------------------------------------------------------------
  localparam int CC_IRQ_ENABLE = 6;
  localparam int CC_MODE_B = 5;
  localparam int CC_MODE_A = 4;
  localparam int CC_ELS_LSB = 2;
  localparam int CC_TOGGLE_ON_OVERFLOW = 1;
  localparam int CC_MAX_DUTY = 0;
  localparam logic [6:0] CHANNEL_CONTROL_RESET = 7'h00;
  localparam logic [1:0] ELS_PORT = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam int SYS_BREAK_CLEAR_ENABLE = 0;
endpackage

/* File: tpc_channel.sv */
// One timer channel: output compare / PWM pin logic and input capture detect
`timescale 1ns/1ps
module tpc_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic modeB,
  input wire logic modeA,
  input wire logic [1:0] edgeLevelSelect,
  input wire logic toggleOnOverflow,
  input wire logic maxDutySelect,
  input wire logic active,
  input wire logic overflowEvent,
  input wire logic compareMatch,
  input wire logic captureIn,
  output logic channelEvent,
  output logic captureEvent,
  output logic pinOut,
  output logic pinOe
);
  logic capPrev_reg;
  logic pin_next;
  logic outMode;
  logic capMode;
  logic compareEvent;
  logic pulseLevel;
  logic rise;
  logic fall;

  assign outMode = enable && (modeB || modeA) && edgeLevelSelect != tpc_pkg::ELS_PORT;
  assign capMode = enable && !modeB && !modeA && edgeLevelSelect != tpc_pkg::ELS_PORT;
  assign compareEvent = outMode && compareMatch;
  assign rise = captureIn && !capPrev_reg;
  assign fall = !captureIn && capPrev_reg;
  assign captureEvent = capMode && active &&
    ((edgeLevelSelect == tpc_pkg::ELS_TOGGLE && rise) ||
     (edgeLevelSelect == tpc_pkg::ELS_CLEAR && fall) ||
     (edgeLevelSelect == tpc_pkg::ELS_SET && (rise || fall)));
  assign channelEvent = captureEvent || compareEvent;
  // Pulse level is the complement of what the compare action drives
  assign pulseLevel = edgeLevelSelect != tpc_pkg::ELS_SET;

  always_ff @(posedge clk) begin
    if (rst) begin
      // Track the pin through reset so a pulled-up idle pin gives no false edge
      capPrev_reg <= captureIn;
    end else begin
      capPrev_reg <= captureIn;
    end
  end

  // ---------------------------------------------------------------
  // Pin level
  // ---------------------------------------------------------------
  always_comb begin
    pin_next = pinOut;
    if (!outMode) begin
      pin_next = !modeA;
    end else if (maxDutySelect && toggleOnOverflow) begin
      pin_next = pulseLevel;
    end else begin
      if (overflowEvent && toggleOnOverflow) begin
        pin_next = !pin_next;
      end
      // Compare applied last so a stray level self-corrects each period
      if (compareEvent) begin
        unique case (edgeLevelSelect)
          tpc_pkg::ELS_TOGGLE: pin_next = !pin_next;
          tpc_pkg::ELS_CLEAR: pin_next = 1'b0;
          tpc_pkg::ELS_SET: pin_next = 1'b1;
          default: pin_next = pin_next;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinOut <= 1'b1;
      pinOe <= 1'b0;
    end else begin
      pinOut <= pin_next;
      pinOe <= outMode;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_zero_duty;
    (outMode && !toggleOnOverflow && !maxDutySelect && edgeLevelSelect != tpc_pkg::ELS_TOGGLE
      && pinOut == (edgeLevelSelect == tpc_pkg::ELS_SET)) |=> $stable(pinOut);
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("pin moved at zero duty");

  property p_full_duty;
    (outMode && maxDutySelect && toggleOnOverflow) |=> pinOut == $past(pulseLevel);
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("pin left pulse level");

  property p_overflow_toggle;
    (outMode && overflowEvent && toggleOnOverflow && !maxDutySelect && !compareEvent)
      |=> pinOut != $past(pinOut);
  endproperty
  a_overflow_toggle: assert property (p_overflow_toggle) else $error("no toggle at overflow");
endmodule

/* File: tpc_load_model.sv */
// External loads on the two timer channel pins
`timescale 1ns/1ps
module tpc_load_model (
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  output logic [1:0] pinLevel
);
  // A released pin is pulled up, so it reads high whatever level was last driven
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : 1'b1;
    end
  end
endmodule

/* File: tpc_timer_pwm_test.sv */
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/1ps
module tpc_timer_pwm_test;
  localparam logic [7:0] TC = tpc_pkg::OFS_TIMER_CONTROL;
  localparam logic [7:0] CNT = tpc_pkg::OFS_COUNTER;
  localparam logic [7:0] MODV = tpc_pkg::OFS_MODULO_VALUE;
  localparam logic [7:0] C0C = tpc_pkg::OFS_FIRST_CHANNEL_CONTROL;
  localparam logic [7:0] C0V = tpc_pkg::OFS_FIRST_CHANNEL_VALUE;
  localparam logic [7:0] C1C = tpc_pkg::OFS_SECOND_CHANNEL_CONTROL;
  localparam logic [7:0] C1V = tpc_pkg::OFS_SECOND_CHANNEL_VALUE;
  localparam logic [7:0] SYS = tpc_pkg::OFS_SYSTEM_CONTROL;
  logic clk, rst, we, cyc, stb, ack, err, waitMode, stopMode, breakActive, irq, e;
  logic [7:0] adr;
  logic [31:0] datW, datR, q, q2;
  logic [3:0] sel;
  logic [1:0] chOut, chOe, pin;
  int badCount, numChecks, h, h1;

  tpc_timer_pwm DUT (.clk(clk), .rst(rst), .adr_i(adr), .dat_i(datW), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(datR), .ack_o(ack), .err_o(err), .waitMode(waitMode),
    .stopMode(stopMode), .breakActive(breakActive), .captureIn(pin), .channelOut(chOut),
    .channelOe(chOe), .irqRequest(irq));
  tpc_load_model LOAD (.pinOut(chOut), .pinOe(chOe), .pinLevel(pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Bus access and checking
  // ---------------------------------------------------------------
  task automatic end_sim;
    if (badCount == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    we <= w;
    datW <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    // Read before this edge's updates land, so ack is the value sampled here
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = datR;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1) begin
      badCount++;
      end_sim();
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic r(input logic [7:0] a);
    bus(a, 1'b0, 32'h0000_0000);
  endtask

  // Lets the output settle for two periods, then counts high cycles on both pins
  task automatic highs;
    repeat (8) @(posedge clk);
    h = 0;
    h1 = 0;
    repeat (16) begin
      @(posedge clk);
      if (pin[0] === 1'b1) h++;
      if (pin[1] === 1'b1) h1++;
    end
  endtask

  task automatic setup(input logic [31:0] ctrl, input logic [31:0] val);
    w(TC, 32'h0000_0030);
    w(MODV, 32'h0000_0003);
    w(C0V, val);
    w(C0C, ctrl);
    w(TC, 32'h0000_0040);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    r(TC);
    chk("control", q & 32'h0000_00f0, 32'h0000_0020);
    r(MODV);
    chk("modulo", q, 32'h0000_ffff);
    r(8'h40);
    chk("unmapped", q, 32'h0000_0000);
  endtask

  task automatic t_unbuffered;
    setup(32'h0000_001a, 32'h0000_0001);
    highs();
    chk("duty", 32'(h), 32'h0000_0008);
    chk("oe0", 32'(chOe[0]), 32'h0000_0001);
    r(TC);
    chk("ovf flag", q, 32'h0000_00c0);
    r(C0C);
    chk("ch flag", q, 32'h0000_009a);
    chk("irq on", 32'(irq), 32'h0000_0001);
    w(TC, 32'h0000_00a0);
    r(TC);
    w(TC, 32'h0000_00a0);
    r(TC);
    chk("write one", q, 32'h0000_00a0);
    w(TC, 32'h0000_0020);
    r(TC);
    chk("flag clear", q, 32'h0000_0020);
    chk("irq masked", 32'(irq), 32'h0000_0000);
  endtask

  // Bounded wait for the first pin to show a level
  task automatic await_pin(input logic lvl);
    int n;
    n = 0;
    while (pin[0] !== lvl && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (pin[0] !== lvl) begin
      badCount++;
      end_sim();
    end
  endtask

  // Widen right after the pulse starts, narrow right after it ends
  task automatic t_resize;
    setup(32'h0000_005a, 32'h0000_0001);
    await_pin(1'b0);
    await_pin(1'b1);
    w(C0V, 32'h0000_0002);
    highs();
    chk("wider", 32'(h), 32'h0000_000c);
    await_pin(1'b1);
    await_pin(1'b0);
    w(C0V, 32'h0000_0000);
    highs();
    chk("narrower", 32'(h), 32'h0000_0004);
  endtask

  task automatic t_duty;
    setup(32'h0000_0018, 32'h0000_0001);
    highs();
    chk("zero duty", 32'(h), 32'h0000_0000);
    setup(32'h0000_001b, 32'h0000_0001);
    highs();
    chk("full duty", 32'(h), 32'h0000_0010);
  endtask

  task automatic t_buffered;
    w(C1C, 32'h0000_001a);
    highs();
    chk("pin1 duty", 32'(h1), 32'h0000_0004);
    setup(32'h0000_002a, 32'h0000_0001);
    chk("pin1 free", 32'(chOe[1]), 32'h0000_0000);
    r(C1C);
    chk("ctl1 unused", q, 32'h0000_0000);
    highs();
    chk("ch0 first", 32'(h), 32'h0000_0008);
    w(C1V, 32'h0000_0002);
    highs();
    chk("ch1 rules", 32'(h), 32'h0000_000c);
    w(C0V, 32'h0000_0000);
    highs();
    chk("ch0 again", 32'(h), 32'h0000_0004);
  endtask

  task automatic t_wait;
    waitMode <= 1'b1;
    w(MODV, 32'h0000_0007);
    chk("wait err", 32'(e), 32'h0000_0001);
    waitMode <= 1'b0;
    r(MODV);
    chk("wait no write", q, 32'h0000_0003);
  endtask

  task automatic t_freeze;
    setup(32'h0000_001a, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) stopMode <= 1'b1;
      else breakActive <= 1'b1;
      r(CNT);
      q2 = q;
      // Gap is not a whole number of 4-cycle periods, so a running counter shows
      repeat (6) @(posedge clk);
      r(CNT);
      chk("frozen", q, q2);
      if (i == 0) stopMode <= 1'b0;
      else breakActive <= 1'b0;
    end
  endtask

  task automatic t_break;
    @(posedge clk);
    breakActive <= 1'b1;
    r(TC);
    w(TC, 32'h0000_0040);
    r(TC);
    chk("flag kept", q, 32'h0000_00c0);
    w(SYS, 32'h0000_0001);
    r(TC);
    w(TC, 32'h0000_0040);
    r(TC);
    chk("break clear", q, 32'h0000_0040);
    breakActive <= 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    datW = 32'h0000_0000;
    sel = 4'h3;
    waitMode = 1'b0;
    stopMode = 1'b0;
    breakActive = 1'b0;
    badCount = 0;
    numChecks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_unbuffered();
    t_resize();
    t_duty();
    t_buffered();
    t_wait();
    t_freeze();
    t_break();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge clk);
    badCount++;
    end_sim();
  end
endmodule
